// File: inc/pwm_dac_pkg.sv
`default_nettype none

package pwm_dac_pkg;

    // ********************************
    // Register addresses
    // ********************************
    localparam logic [7:0] ADDR_PRESCALE = 8'hda;
    localparam logic [7:0] ADDR_DUTY_A = 8'hdb;
    localparam logic [7:0] ADDR_DUTY_B = 8'hdc;
    localparam logic [7:0] ADDR_CONTROL = 8'hfe;

    // ********************************
    // Control fields
    // ********************************
    localparam int CTRL_MASTER_BIT = 7;
    localparam int CTRL_ENA_A_BIT = 1;
    localparam int CTRL_ENA_B_BIT = 0;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [7:0] RESET_PRESCALE = 8'h00;
    localparam logic [7:0] RESET_DUTY = 8'h00;
    localparam logic RESET_ENABLE = 1'b0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ********************************
    // Timing counts
    // ********************************
    localparam logic [7:0] PERIOD_LAST = 8'hfe;
    localparam logic [7:0] COUNT_START = 8'h00;

endpackage

`default_nettype wire

// File: core/pwm_compare_channel.sv
`default_nettype none

module pwm_compare_channel
    import pwm_dac_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Compare inputs
    input wire logic enable_in,
    input wire logic [WIDTH-1:0] count_in,
    input wire logic [WIDTH-1:0] duty_in,
    // Waveform
    output logic wave_out
);

    logic next_wave;

    // Inverted duty: high once the count reaches the duty value, so
    // zero never goes low and all ones never goes high
    always_comb begin
        next_wave = enable_in && (count_in >= duty_in);
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            wave_out <= RESET_ENABLE;
        end else begin
            wave_out <= next_wave;
        end
    end

endmodule

`default_nettype wire

// File: core/dual_pwm_dac.sv
// Summary of operation
// - Master enable runs halver, prescaler, period counter
// - Output A modulates only while enabled
// - Output B modulates only while enabled
// - Control at FEH, bits six-two unused
// - Prescale register at DAH sets division
// - Duty A register at DBH feeds A
// - Duty B register at DCH feeds B
// - Inverted duty: zero high, all-ones low
`default_nettype none

module dual_pwm_dac
    import pwm_dac_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // Modulated outputs
    output logic analog_out_a_out,
    output logic analog_out_b_out
);

    // ********************************
    // Registers
    // ********************************
    logic [WIDTH-1:0] prescale_value;
    logic [WIDTH-1:0] duty_value_a;
    logic [WIDTH-1:0] duty_value_b;
    logic modulator_master_enable;
    logic output_a_enable;
    logic output_b_enable;
    logic [7:0] read_data;

    logic [WIDTH-1:0] next_prescale_value;
    logic [WIDTH-1:0] next_duty_value_a;
    logic [WIDTH-1:0] next_duty_value_b;
    logic next_master;
    logic next_ena_a;
    logic next_ena_b;
    logic [7:0] next_read_data;
    logic [7:0] control_view;

    always_comb begin
        next_prescale_value = prescale_value;
        next_duty_value_a = duty_value_a;
        next_duty_value_b = duty_value_b;
        next_master = modulator_master_enable;
        next_ena_a = output_a_enable;
        next_ena_b = output_b_enable;
        control_view = 8'h00;
        control_view[CTRL_MASTER_BIT] = modulator_master_enable;
        control_view[CTRL_ENA_A_BIT] = output_a_enable;
        control_view[CTRL_ENA_B_BIT] = output_b_enable;
        if (sfr_wr_in) begin
            case (sfr_addr_in)
                ADDR_PRESCALE: begin
                    next_prescale_value = sfr_wdata_in;
                end
                ADDR_DUTY_A: begin
                    next_duty_value_a = sfr_wdata_in;
                end
                ADDR_DUTY_B: begin
                    next_duty_value_b = sfr_wdata_in;
                end
                ADDR_CONTROL: begin
                    // Bits six to two are not stored at all
                    next_master = sfr_wdata_in[CTRL_MASTER_BIT];
                    next_ena_a = sfr_wdata_in[CTRL_ENA_A_BIT];
                    next_ena_b = sfr_wdata_in[CTRL_ENA_B_BIT];
                end
                default: begin
                end
            endcase
        end
        next_read_data = read_data;
        if (sfr_rd_in) begin
            case (sfr_addr_in)
                ADDR_PRESCALE: next_read_data = prescale_value;
                ADDR_DUTY_A: next_read_data = duty_value_a;
                ADDR_DUTY_B: next_read_data = duty_value_b;
                ADDR_CONTROL: next_read_data = control_view;
                default: next_read_data = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            prescale_value <= RESET_PRESCALE;
            duty_value_a <= RESET_DUTY;
            duty_value_b <= RESET_DUTY;
            modulator_master_enable <= RESET_ENABLE;
            output_a_enable <= RESET_ENABLE;
            output_b_enable <= RESET_ENABLE;
            read_data <= READ_UNMAPPED;
        end else begin
            prescale_value <= next_prescale_value;
            duty_value_a <= next_duty_value_a;
            duty_value_b <= next_duty_value_b;
            modulator_master_enable <= next_master;
            output_a_enable <= next_ena_a;
            output_b_enable <= next_ena_b;
            read_data <= next_read_data;
        end
    end

    assign sfr_rdata_out = read_data;

    // ********************************
    // Clock chain
    // ********************************
    logic half_phase;
    logic [WIDTH-1:0] pre_count;
    logic [WIDTH-1:0] period_count;
    logic next_half_phase;
    logic [WIDTH-1:0] next_pre_count;
    logic [WIDTH-1:0] next_period_count;
    logic half_tick;
    logic period_tick;

    // Prescaler divides the half rate by value plus one, so zero still
    // advances the counter at the half rate
    // At-or-above match: a smaller value written mid-step ends the step
    // at once instead of letting the count run all the way round
    always_comb begin
        half_tick = half_phase;
        period_tick = half_tick && (pre_count >= prescale_value);
        next_half_phase = !half_phase;
        next_pre_count = pre_count;
        next_period_count = period_count;
        if (half_tick) begin
            next_pre_count = period_tick ? COUNT_START :
                             pre_count + 1'b1;
        end
        if (period_tick) begin
            next_period_count = (period_count == PERIOD_LAST) ?
                                COUNT_START :
                                period_count + 1'b1;
        end
        if (!modulator_master_enable) begin
            // Whole chain parked so a restart begins a clean period
            next_half_phase = 1'b0;
            next_pre_count = COUNT_START;
            next_period_count = COUNT_START;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            half_phase <= 1'b0;
            pre_count <= COUNT_START;
            period_count <= COUNT_START;
        end else begin
            half_phase <= next_half_phase;
            pre_count <= next_pre_count;
            period_count <= next_period_count;
        end
    end

    // ********************************
    // Output channels
    // ********************************
    logic run_a;
    logic run_b;

    assign run_a = modulator_master_enable && output_a_enable;
    assign run_b = modulator_master_enable && output_b_enable;

    pwm_compare_channel #(
        .WIDTH(WIDTH)
    ) u_chan_a (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .enable_in(run_a),
        .count_in(period_count),
        .duty_in(duty_value_a),
        .wave_out(analog_out_a_out)
    );

    pwm_compare_channel #(
        .WIDTH(WIDTH)
    ) u_chan_b (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .enable_in(run_b),
        .count_in(period_count),
        .duty_in(duty_value_b),
        .wave_out(analog_out_b_out)
    );

    // ********************************
    // Checks
    // ********************************
    chk_chain_parked: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        !modulator_master_enable |=>
            (pre_count == COUNT_START) && (period_count == COUNT_START))
        else $error("Clock chain not parked while master is off");

    chk_period_wrap: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (modulator_master_enable && period_tick &&
         period_count == PERIOD_LAST) |=> (period_count == COUNT_START))
        else $error("Period counter did not wrap after 254");

    chk_out_a_off: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        !(modulator_master_enable && output_a_enable) |=>
            !analog_out_a_out)
        else $error("Output A active while disabled");

    chk_out_b_off: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        !(modulator_master_enable && output_b_enable) |=>
            !analog_out_b_out)
        else $error("Output B active while disabled");

    chk_ctrl_unused: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (sfr_rd_in && sfr_addr_in == ADDR_CONTROL) |=>
            (sfr_rdata_out[6:2] == 5'h0) &&
            (sfr_rdata_out[7] == $past(modulator_master_enable)))
        else $error("Control read shows unused bits or wrong enable");

    chk_prescale_write: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (sfr_wr_in && sfr_addr_in == ADDR_PRESCALE) |=>
            (prescale_value == $past(sfr_wdata_in)))
        else $error("Prescale write not stored");

    chk_duty_a_write: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (sfr_wr_in && sfr_addr_in == ADDR_DUTY_A) |=>
            (duty_value_a == $past(sfr_wdata_in)))
        else $error("Duty A write not stored");

    chk_duty_b_write: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (sfr_wr_in && sfr_addr_in == ADDR_DUTY_B) |=>
            (duty_value_b == $past(sfr_wdata_in)))
        else $error("Duty B write not stored");

    chk_duty_zero_high: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (run_a && duty_value_a == 8'h00) |=> analog_out_a_out)
        else $error("Duty zero did not hold output A high");

    chk_duty_full_low: assert property (
        @(posedge clk_in) disable iff (!rstn_in)
        (duty_value_b == 8'hff) |=> !analog_out_b_out)
        else $error("Duty all-ones did not hold output B low");

endmodule

`default_nettype wire

// File: test/rc_filter_model.sv
`default_nettype none

module rc_filter_model (
    // Clock and window control
    input wire logic clk_in,
    input wire logic clear_in,
    // Modulated input and integrated charge
    input wire logic wave_in,
    output var int charge_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Very long time constant: charge is the high time in the window
    always_ff @(posedge clk_in) begin
        if (clear_in) begin
            charge_out <= 0;
        end else begin
            charge_out <= charge_out + int'(wave_in);
        end
    end
endmodule

`default_nettype wire

// File: test/dual_pwm_dac_generator_tb_top.sv
`default_nettype none

module dual_pwm_dac_generator_tb_top import pwm_dac_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic out_a;
    logic out_b;
    logic clr = 1'b1;
    int charge_a;
    int charge_b;
    int miscompares = 0;
    int n_compared = 0;
    // Address, write data, read-back value
    localparam logic [23:0] REG_ROWS [5] = '{24'hda_5a5a, 24'hdb_3c3c,
        24'hdc_c3c3, 24'hfe_ff83, 24'h10_7700};
    // Duty A (B gets its inverse), high cycles A, high cycles B
    localparam logic [39:0] DUTY_ROWS [5] = '{40'h00_01fe_0000,
        40'h01_01fc_0002, 40'h80_00fe_0100, 40'hfe_0002_01fc,
        40'hff_0000_01fe};
    // Control value, high cycles A, high cycles B
    localparam logic [39:0] ENA_ROWS [5] = '{40'h82_00fe_0000,
        40'h81_0000_0100, 40'h03_0000_0000, 40'h7f_0000_0000,
        40'h80_0000_0000};

    dual_pwm_dac #(.WIDTH(8)) dut_u (
        .clk_in(clk_in), .rstn_in(rstn_in), .sfr_addr_in(addr),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata),
        .sfr_rdata_out(rdata), .analog_out_a_out(out_a),
        .analog_out_b_out(out_b));
    rc_filter_model rc_a_u (.clk_in(clk_in), .clear_in(clr),
        .wave_in(out_a), .charge_out(charge_a));
    rc_filter_model rc_b_u (.clk_in(clk_in), .clear_in(clr),
        .wave_in(out_b), .charge_out(charge_b));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        @(posedge clk_in);
        #1;
        d = rdata;
    endtask

    // Settle a few cycles first so the window sees a steady waveform
    task automatic measure(input int n, input logic [39:0] row);
        @(posedge clk_in);
        clr <= 1'b1;
        repeat (4) @(posedge clk_in);
        clr <= 1'b0;
        repeat (n) @(posedge clk_in);
        #1;
        check(16'(charge_a), row[31:16]);
        check(16'(charge_b), row[15:0]);
    endtask

    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #100us;
        miscompares++;
        results();
    end

    initial begin
        logic [7:0] v;
        logic [39:0] row;
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        #1;
        check({14'h0, out_a, out_b}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            reg_rd(REG_ROWS[i][23:16], v);
            check({8'h00, v}, 16'h0000);
        end
        for (int i = 0; i < 5; i++) begin
            reg_wr(REG_ROWS[i][23:16], REG_ROWS[i][15:8]);
        end
        for (int i = 0; i < 5; i++) begin
            reg_rd(REG_ROWS[i][23:16], v);
            check({8'h00, v}, {8'h00, REG_ROWS[i][7:0]});
        end
        reg_wr(ADDR_PRESCALE, 8'h00);
        for (int i = 0; i < 5; i++) begin
            row = DUTY_ROWS[i];
            reg_wr(ADDR_DUTY_A, row[39:32]);
            reg_wr(ADDR_DUTY_B, ~row[39:32]);
            measure(510, row);
        end
        reg_wr(ADDR_DUTY_A, 8'h80);
        reg_wr(ADDR_DUTY_B, 8'h7f);
        for (int i = 0; i < 5; i++) begin
            reg_wr(ADDR_CONTROL, ENA_ROWS[i][39:32]);
            measure(510, ENA_ROWS[i]);
        end
        // Prescale of one doubles the period
        reg_wr(ADDR_CONTROL, 8'h83);
        reg_wr(ADDR_PRESCALE, 8'h01);
        measure(1020, 40'h00_01fc_0200);
        // Reset in mid-run
        @(posedge clk_in);
        rstn_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        check({14'h0, out_a, out_b}, 16'h0000);
        @(posedge clk_in);
        rstn_in <= 1'b1;
        #1;
        check({14'h0, out_a, out_b}, 16'h0000);
        reg_rd(ADDR_CONTROL, v);
        check({8'h00, v}, 16'h0000);
        reg_rd(ADDR_PRESCALE, v);
        check({8'h00, v}, 16'h0000);
        results();
    end
endmodule

`default_nettype wire
